// >>> core/ppc_pkg.sv
// package for the per-port transceiver control register bank
package ppc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_PORTS = 2;
    // register byte offsets per port
    localparam logic [7:0] P1_FAULT_LOW_OFS = 8'h1B;
    localparam logic [7:0] P1_NEG_CTRL_OFS = 8'h1C;
    localparam logic [7:0] P1_FUNC_CTRL_OFS = 8'h1D;
    localparam logic [7:0] P2_FAULT_LOW_OFS = 8'h2B;
    localparam logic [7:0] P2_NEG_CTRL_OFS = 8'h2C;
    localparam logic [7:0] P2_FUNC_CTRL_OFS = 8'h2D;
    // negotiation control fields
    localparam int NEG_AN_EN_BIT = 7;
    localparam int NEG_SPEED_BIT = 6;
    localparam int NEG_DUPLEX_BIT = 5;
    localparam logic [4:0] NEG_ADV_RESET = 5'h1F;
    // function control fields
    localparam int FN_LED_OFF_BIT = 7;
    localparam int FN_TX_DIS_BIT = 6;
    localparam int FN_RESTART_AN_BIT = 5;
    localparam int FN_FEF_DIS_BIT = 4;
    localparam int FN_POWER_DOWN_BIT = 3;
    localparam int FN_XOVER_DIS_BIT = 2;
    localparam int FN_FORCE_MDI_BIT = 1;
    localparam int FN_LOOPBACK_BIT = 0;
    localparam logic [7:0] FN_CTRL_RESET = 8'h00;
    localparam logic [7:0] FAULT_LOW_RESET = 8'h00;
    // cable fault distance step in millimetres per count
    localparam int FAULT_STEP_MM = 400;
endpackage : ppc_pkg

// >>> core/ppc_port_ctrl.sv
// one port's control registers and decoded controls
`timescale 1ns/1ns
`default_nettype none
module ppc_port_ctrl (
    input wire logic clock,
    input wire logic resetn,
    input wire logic neg_strap,
    input wire logic speed_strap,
    input wire logic duplex_strap,
    input wire logic neg_wr,
    input wire logic func_wr,
    input wire logic [7:0] wdata,
    input wire logic an_failed,
    input wire logic led_one_in,
    input wire logic led_zero_in,
    output logic [7:0] neg_ctrl,
    output logic [7:0] func_ctrl,
    output logic an_enable,
    output logic speed_100,
    output logic full_duplex,
    output logic [3:0] advertise,
    output logic advertise_pause,
    output logic port_led_one,
    output logic port_led_zero,
    output logic tx_disable,
    output logic restart_an,
    output logic fef_enable,
    output logic power_down,
    output logic auto_xover,
    output logic tx_on_receive_pair,
    output logic loopback
);
    logic [7:0] neg_r;
    logic [7:0] neg_nxt;
    logic [7:0] func_r;
    logic [7:0] func_nxt;

    // ************************
    // register update
    // ************************
    always_comb begin
        neg_nxt = neg_r;
        func_nxt = func_r;
        if (!resetn) begin
            // strap levels captured by the clocked reset, never async
            neg_nxt = {neg_strap, speed_strap, duplex_strap, ppc_pkg::NEG_ADV_RESET};
            func_nxt = ppc_pkg::FN_CTRL_RESET;
        end else begin
            if (neg_wr) begin
                neg_nxt = wdata;
            end
            if (func_wr) begin
                func_nxt = wdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        neg_r <= neg_nxt;
        func_r <= func_nxt;
    end

    // ************************
    // decoded controls
    // ************************
    assign neg_ctrl = neg_r;
    assign func_ctrl = func_r;
    assign an_enable = neg_r[ppc_pkg::NEG_AN_EN_BIT];
    // forced speed only matters while negotiation is off
    assign speed_100 = neg_r[ppc_pkg::NEG_SPEED_BIT];
    // duplex bit also covers a failed negotiation
    assign full_duplex = neg_r[ppc_pkg::NEG_DUPLEX_BIT] & (~an_enable | an_failed);
    assign advertise_pause = neg_r[4];
    assign advertise = neg_r[3:0];
    assign port_led_one = func_r[ppc_pkg::FN_LED_OFF_BIT] ? 1'b1 : led_one_in;
    assign port_led_zero = func_r[ppc_pkg::FN_LED_OFF_BIT] ? 1'b1 : led_zero_in;
    assign tx_disable = func_r[ppc_pkg::FN_TX_DIS_BIT];
    assign restart_an = func_r[ppc_pkg::FN_RESTART_AN_BIT];
    assign power_down = func_r[ppc_pkg::FN_POWER_DOWN_BIT];
    assign fef_enable = ~func_r[ppc_pkg::FN_FEF_DIS_BIT];
    assign auto_xover = ~func_r[ppc_pkg::FN_XOVER_DIS_BIT];
    assign tx_on_receive_pair = func_r[ppc_pkg::FN_FORCE_MDI_BIT];
    assign loopback = func_r[ppc_pkg::FN_LOOPBACK_BIT];
endmodule : ppc_port_ctrl
`default_nettype wire

// >>> core/ppc_top.sv
// control register bank for the two transceiver ports
`timescale 1ns/1ns
`default_nettype none
// How it works
// - read-only low eight bits of cable fault count per port, reset zero
// - ninth fault count bit comes from bit 8 of each port's fault_count_in field
// - negotiation enable bit 7 set autonegotiates, clear uses forced bits
// - forced speed bit 6: one gives 100 Mb/s, zero gives 10
// - duplex bit 5 full/half when negotiation off or failed
// - negotiation, speed, duplex reset values from per-port straps at reset
// - bits 4..0 advertise pause and four speed modes, reset to one
// - LED off bit 7 drives both port LED pins high
// - bit 6 transmitter off, bit 5 restart negotiation, bit 3 power down
// - bit 4 disables far-end fault detection and pattern transmission
// - bit 2 disables automatic crossover selection
// - forced crossover: bit 1 one transmits on receive pair, else transmit pair
// - loopback on one port sets that same port's own bit of loop_source_port
// - function control register resets to zero, normal operation
module ppc_top #(
    parameter int NUM_PORTS = ppc_pkg::NUM_PORTS
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic port1_negotiation_strap,
    input wire logic port1_speed_strap,
    input wire logic port1_duplex_strap,
    input wire logic port2_negotiation_strap,
    input wire logic port2_speed_strap,
    input wire logic port2_duplex_strap,
    input wire logic [17:0] fault_count_in,
    input wire logic [1:0] fault_count_valid,
    input wire logic [1:0] an_failed,
    input wire logic [1:0] led_one_in,
    input wire logic [1:0] led_zero_in,
    output logic [1:0] fault_count_high,
    output logic [1:0] an_enable,
    output logic [1:0] speed_100,
    output logic [1:0] full_duplex,
    output logic [7:0] advertise,
    output logic [1:0] advertise_pause,
    output logic [1:0] port_led_one,
    output logic [1:0] port_led_zero,
    output logic [1:0] tx_disable,
    output logic [1:0] restart_an,
    output logic [1:0] fef_enable,
    output logic [1:0] power_down,
    output logic [1:0] auto_xover,
    output logic [1:0] tx_on_receive_pair,
    output logic [1:0] loopback,
    output logic [1:0] loop_source_port
);
    // ************************
    // address decode
    // ************************
    function automatic logic [2:0] ppc_decode(input logic [7:0] addr, input int port);
        logic [7:0] base;
        base = (port == 0) ? ppc_pkg::P1_FAULT_LOW_OFS : ppc_pkg::P2_FAULT_LOW_OFS;
        ppc_decode = {addr == base + 8'h02, addr == base + 8'h01, addr == base};
    endfunction : ppc_decode

    logic [7:0] fault_low_r [2];
    logic [7:0] fault_low_nxt [2];
    logic [1:0] fault_high_r;
    logic [1:0] fault_high_nxt;
    logic [7:0] neg_ctrl [2];
    logic [7:0] func_ctrl [2];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [1:0] strap_neg;
    logic [1:0] strap_spd;
    logic [1:0] strap_dpx;

    assign strap_neg = {port2_negotiation_strap, port1_negotiation_strap};
    assign strap_spd = {port2_speed_strap, port1_speed_strap};
    assign strap_dpx = {port2_duplex_strap, port1_duplex_strap};

    // ************************
    // per-port control
    // ************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            logic [2:0] hit;
            assign hit = ppc_decode(reg_addr, gi);
            ppc_port_ctrl u_port (
                .clock(clock),
                .resetn(resetn),
                .neg_strap(strap_neg[gi]),
                .speed_strap(strap_spd[gi]),
                .duplex_strap(strap_dpx[gi]),
                .neg_wr(reg_write & hit[1]),
                .func_wr(reg_write & hit[2]),
                .wdata(reg_wdata),
                .an_failed(an_failed[gi]),
                .led_one_in(led_one_in[gi]),
                .led_zero_in(led_zero_in[gi]),
                .neg_ctrl(neg_ctrl[gi]),
                .func_ctrl(func_ctrl[gi]),
                .an_enable(an_enable[gi]),
                .speed_100(speed_100[gi]),
                .full_duplex(full_duplex[gi]),
                .advertise(advertise[gi*4 +: 4]),
                .advertise_pause(advertise_pause[gi]),
                .port_led_one(port_led_one[gi]),
                .port_led_zero(port_led_zero[gi]),
                .tx_disable(tx_disable[gi]),
                .restart_an(restart_an[gi]),
                .fef_enable(fef_enable[gi]),
                .power_down(power_down[gi]),
                .auto_xover(auto_xover[gi]),
                .tx_on_receive_pair(tx_on_receive_pair[gi]),
                .loopback(loopback[gi])
            );
            // loopback on this port sets this same port's bit of loop_source_port
            assign loop_source_port[gi] = loopback[gi];
        end
    endgenerate

    // ************************
    // fault count capture
    // ************************
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            fault_low_nxt[i] = fault_low_r[i];
            fault_high_nxt[i] = fault_high_r[i];
            if (!resetn) begin
                fault_low_nxt[i] = ppc_pkg::FAULT_LOW_RESET;
                fault_high_nxt[i] = 1'b0;
            end else if (fault_count_valid[i]) begin
                // distance is about 0.4 m per count of the nine-bit value
                fault_low_nxt[i] = fault_count_in[i*9 +: 8];
                fault_high_nxt[i] = fault_count_in[i*9 + 8];
            end
        end
    end

    always_ff @(posedge clock) begin
        fault_low_r <= fault_low_nxt;
        fault_high_r <= fault_high_nxt;
    end

    assign fault_count_high = fault_high_r;

    // ************************
    // read path
    // ************************
    // registered read data; unmapped offsets return zero
    always_comb begin
        logic [2:0] h0;
        logic [2:0] h1;
        h0 = ppc_decode(reg_addr, 0);
        h1 = ppc_decode(reg_addr, 1);
        rdata_nxt = rdata_r;
        if (!resetn) begin
            rdata_nxt = 8'h00;
        end else if (reg_read) begin
            rdata_nxt = 8'h00;
            if (h0[0]) rdata_nxt = fault_low_r[0];
            if (h0[1]) rdata_nxt = neg_ctrl[0];
            if (h0[2]) rdata_nxt = func_ctrl[0];
            if (h1[0]) rdata_nxt = fault_low_r[1];
            if (h1[1]) rdata_nxt = neg_ctrl[1];
            if (h1[2]) rdata_nxt = func_ctrl[1];
        end
    end

    always_ff @(posedge clock) begin
        rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;
endmodule : ppc_top
`default_nettype wire

// >>> tb/ppc_host.sv
// host model issuing management register accesses
`timescale 1ns/1ns
`default_nettype none
module ppc_host (
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
        // released lines must not keep the old value
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : ppc_host
`default_nettype wire

// >>> tb/ppc_properties.sv
// checker for the port control register bank
`timescale 1ns/1ns
`default_nettype none
module ppc_properties (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] an_failed,
    input wire logic [1:0] an_enable,
    input wire logic [1:0] speed_100,
    input wire logic [1:0] full_duplex,
    input wire logic [1:0] port_led_one,
    input wire logic [1:0] tx_disable,
    input wire logic [1:0] fef_enable,
    input wire logic [1:0] auto_xover,
    input wire logic [1:0] loopback
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence wr_p1f; reg_write && reg_addr == 8'h1D; endsequence
    sequence wr_p2f; reg_write && reg_addr == 8'h2D; endsequence
    sequence wr_p1n; reg_write && reg_addr == 8'h1C; endsequence
    a_led_blank: assert property (wr_p1f ##0 reg_wdata[7] |=> port_led_one[0])
        else $error("led not blanked");
    a_txdis_follow: assert property (wr_p1f |=> tx_disable[0] == $past(reg_wdata[6]))
        else $error("tx disable wrong");
    a_fef_invert: assert property (wr_p1f |=> fef_enable[0] == !$past(reg_wdata[4]))
        else $error("far-end fault enable wrong");
    a_xover_ctrl: assert property (wr_p2f |=> auto_xover[1] == !$past(reg_wdata[2]))
        else $error("crossover control wrong");
    a_loop_ctrl: assert property (wr_p2f |=> loopback[1] == $past(reg_wdata[0]))
        else $error("loopback wrong");
    a_forced_mode: assert property (wr_p1n |=> an_enable[0] == $past(reg_wdata[7])
        && speed_100[0] == $past(reg_wdata[6])) else $error("negotiation mode wrong");
    a_duplex_gate: assert property (an_enable[0] && !an_failed[0] |-> !full_duplex[0])
        else $error("duplex forced while negotiating");
    a_read_func: assert property (reg_read && !reg_write && reg_addr == 8'h1D
        |=> reg_rdata[6] == tx_disable[0]) else $error("read data mismatch");
    a_reset_ctrl: assert property ($rose(resetn) |-> tx_disable == 2'b00
        && loopback == 2'b00 && auto_xover == 2'b11) else $error("reset value wrong");
endmodule : ppc_properties
bind ppc_top ppc_properties u_props (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .an_failed, .an_enable, .speed_100, .full_duplex, .port_led_one,
    .tx_disable, .fef_enable, .auto_xover, .loopback);
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the port control register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clock, resetn, reg_write, reg_read;
    logic [5:0] strap;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, advertise, rd_v;
    logic [17:0] fault_count_in;
    logic [1:0] fault_count_valid, an_failed, led_one_in, led_zero_in, fault_count_high;
    logic [1:0] an_enable, speed_100, full_duplex, advertise_pause, port_led_one;
    logic [1:0] port_led_zero, tx_disable, restart_an, fef_enable, power_down, auto_xover;
    logic [1:0] tx_on_receive_pair, loopback, loop_source_port;
    int err_total = 0;
    int n_checks = 0;
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    ppc_host host (.clock, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read);
    ppc_top dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .port1_negotiation_strap(strap[5]), .port1_speed_strap(strap[4]),
        .port1_duplex_strap(strap[3]), .port2_negotiation_strap(strap[2]),
        .port2_speed_strap(strap[1]), .port2_duplex_strap(strap[0]), .fault_count_in,
        .fault_count_valid, .an_failed, .led_one_in, .led_zero_in, .fault_count_high,
        .an_enable, .speed_100, .full_duplex, .advertise, .advertise_pause, .port_led_one,
        .port_led_zero, .tx_disable, .restart_an, .fef_enable, .power_down, .auto_xover,
        .tx_on_receive_pair, .loopback, .loop_source_port);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    // straps change between resets, so defaults must follow them
    task automatic t_reset(input logic [5:0] s);
        @(negedge clock);
        strap = s;
        resetn = 1'b0;
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        host.rd(8'h1C, rd_v);
        chk(rd_v, {s[5:3], 5'h1F});
        host.rd(8'h2C, rd_v);
        chk(rd_v, {s[2:0], 5'h1F});
        for (int i = 0; i < 4; i++) begin
            host.rd({i[1] ? 4'h2 : 4'h1, i[0] ? 4'hD : 4'hB}, rd_v);
            chk(rd_v, 8'h00);
        end
    endtask : t_reset
    task automatic t_neg;
        host.wr(8'h1C, 8'h4A);
        chk({an_enable[0], speed_100[0], full_duplex[0], advertise_pause[0], advertise[3:0]},
            8'h4A);
        host.wr(8'h2C, 8'h35);
        chk({an_enable[1], speed_100[1], full_duplex[1], advertise_pause[1], advertise[7:4]},
            8'h35);
        host.wr(8'h1C, 8'hA0);
        chk({5'h00, an_enable[0], speed_100[0], full_duplex[0]}, 8'h04);
        an_failed = 2'b01;
        @(negedge clock);
        chk({7'h00, full_duplex[0]}, 8'h01);
        host.rd(8'h1C, rd_v);
        chk(rd_v, 8'hA0);
    endtask : t_neg
    task automatic t_func;
        for (int i = 0; i < 8; i++) begin
            host.wr(8'h2D, 8'h01 << i);
            chk({port_led_one[1] & port_led_zero[1], tx_disable[1], restart_an[1],
                ~fef_enable[1], power_down[1], ~auto_xover[1], tx_on_receive_pair[1],
                loopback[1]}, 8'h01 << i);
            chk({6'h00, loop_source_port}, (i == 0) ? 8'h02 : 8'h00);
        end
        host.wr(8'h1D, 8'hD0);
        chk({port_led_one[0], port_led_zero[0], tx_disable[0], fef_enable[0], 4'h0},
            8'hE0);
        host.rd(8'h1D, rd_v);
        chk(rd_v, 8'hD0);
        // normal levels must pass through once blanking is off
        led_one_in = 2'b11;
        host.wr(8'h2D, 8'h00);
        chk({4'h0, port_led_one, port_led_zero}, 8'h0D);
    endtask : t_func
    task automatic t_fault;
        @(negedge clock);
        fault_count_in = {9'h0F3, 9'h1A5};
        fault_count_valid = 2'b11;
        @(negedge clock);
        fault_count_valid = 2'b00;
        fault_count_in = 18'h00000;
        host.wr(8'h1B, 8'h00);
        host.rd(8'h1B, rd_v);
        chk(rd_v, 8'hA5);
        host.rd(8'h2B, rd_v);
        chk(rd_v, 8'hF3);
        chk({6'h00, fault_count_high}, 8'h01);
        host.rd(8'h30, rd_v);
        chk(rd_v, 8'h00);
    endtask : t_fault
    initial begin
        resetn = 1'b0;
        strap = 6'h00;
        fault_count_in = 18'h00000;
        fault_count_valid = 2'b00;
        an_failed = 2'b00;
        led_one_in = 2'b00;
        led_zero_in = 2'b00;
        t_reset(6'h2A);
        t_neg();
        t_func();
        t_fault();
        t_reset(6'h15);
        test_done();
    end
    initial begin
        #1000000;
        err_total++;
        test_done();
    end
endmodule : testbench
`default_nettype wire
